// ### core/oam_pkg.sv
// Purpose: Shared constants and carriers for the OAM loopback, test and loss engine.
// Assumes: APB register access with 32-bit data words.
// Notes: Offsets are byte addresses.
package oam_pkg;
	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_TX_TID = 12'h004;
	localparam logic [11:0] OFS_RX_TID = 12'h008;
	localparam logic [11:0] OFS_LBR_CNT = 12'h00c;
	localparam logic [11:0] OFS_LB_IDX = 12'h010;
	localparam logic [11:0] OFS_PROT = 12'h014;
	localparam logic [11:0] OFS_MAC_LO = 12'h018;
	localparam logic [11:0] OFS_MAC_HI = 12'h01c;
	localparam logic [11:0] OFS_FWD = 12'h020;
	localparam logic [11:0] OFS_SEQ = 12'h024;
	localparam logic [3:0] CNT_PAGE = 4'h1;
	localparam logic [5:0] CNT_NUM = 6'h30;
	// ----------------------------------------------------------------
	// Control bits and fields
	// ----------------------------------------------------------------
	localparam int C_HW = 0;
	localparam int C_UPD = 1;
	localparam int C_UPLB = 2;
	localparam int C_REQ_CP = 3;
	localparam int C_REP_CP = 4;
	localparam int C_YEL = 5;
	localparam int C_PROT = 6;
	localparam int C_UP = 7;
	localparam int C_PATH = 8;
	localparam int C_OCNT = 9;
	localparam int C_MERGE = 16;
	localparam int FWD_TST = 6;
	localparam int DCTL = 8;
	localparam int SEQ_LMM = 26;
	localparam int SEQ_LMR = 21;
	localparam int SEQ_CCM = 16;
	localparam int REW_SEQ = 27;
	localparam int TID_UP_W = 16;
	localparam logic [2:0] TOP_CLS = 3'h7;
	localparam logic [1:0] SET_SVC = 2'h0;
	localparam logic [1:0] SET_PATH = 2'h1;
	localparam logic [1:0] SET_PORT = 2'h2;
	localparam logic [1:0] MEL_LOW = 2'h0;
	localparam logic [1:0] MEL_SAME = 2'h1;
	localparam logic [1:0] MEL_HIGH = 2'h2;
	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {K_DATA, K_LBM, K_LBR, K_TST, K_LMM, K_LMR, K_CCM_LM, K_OTHER} oam_kind_t;
	typedef struct packed {
		logic valid;
		logic rx;
		oam_kind_t kind;
		logic [1:0] mel;
		logic [2:0] cos;
		logic yellow;
		logic svc;
		logic port_hit;
		logic [3:0] port;
		logic [9:0] ingress_service_index;
		logic [47:0] dmac;
		logic [47:0] smac;
		logic [31:0] tid;
	} oam_evt_t;
	typedef struct packed {
		logic valid;
		logic is_lbr;
		logic discard;
		logic cpu_copy;
		logic seq_err;
		logic [3:0] port;
		logic [9:0] ingress_service_index;
		logic [47:0] dmac;
		logic [47:0] smac;
		logic [31:0] tid;
		logic [31:0] rew;
	} oam_res_t;
endpackage

// ### core/oam_engine.sv
// Purpose: Loopback, test-frame and loss-measurement logic of one OAM endpoint.
// Assumes: One frame event per cycle, already classified by the pipeline.
// Notes: Results leave one cycle after the event; registers sit behind APB.
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
module oam_engine (
	input wire logic pclk, // APB and system clock.
	input wire logic presetn, // Asynchronous reset, active low.
	input wire logic psel, // APB select.
	input wire logic penable, // APB access phase.
	input wire logic pwrite, // APB direction.
	input wire logic [11:0] paddr, // APB byte address.
	input wire logic [31:0] pwdata, // APB write data.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error on unmapped address.
	input wire oam_pkg::oam_evt_t evt, // Classified frame event.
	output oam_pkg::oam_res_t res // Frame verdict and rewrite.
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] tx_tid;
		logic [31:0] rx_tid;
		logic [31:0] lbr_cnt;
		logic [31:0] lb_idx;
		logic [31:0] prot;
		logic [31:0] mac_lo;
		logic [31:0] mac_hi;
		logic [31:0] fwd;
		logic [31:0] seq;
		logic [47:0][31:0] cnt;
		oam_pkg::oam_res_t res;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} oam_state_t;
	oam_state_t st;
	oam_state_t next_st;
	logic lb_on;
	logic tst_on;
	logic same;
	logic tx_hit;
	logic rx_rep;
	logic rx_req;
	logic lm_hit;
	logic cnt_hit;
	logic conv;
	logic [2:0] cls;
	logic [31:0] exp_tid;
	logic [4:0] nseq;
	logic wr_go;

	// Counter slot from set, direction and class.
	function automatic logic [5:0] cidx(input logic [1:0] set, input logic tx, input logic [2:0] c);
		cidx = {set, tx, c};
	endfunction

	// Address decode shared by read and write.
	function automatic logic mapped(input logic [11:0] a);
		mapped = (a[11:8] == oam_pkg::CNT_PAGE) ? (a[7:2] < oam_pkg::CNT_NUM) :
			(a <= oam_pkg::OFS_SEQ && a[1:0] == 2'h0);
	endfunction

	// ----------------------------------------------------------------
	// Frame classification
	// ----------------------------------------------------------------
	// TST borrows the loopback registers, so the mask bit excludes loopback.
	assign tst_on = st.fwd[oam_pkg::FWD_TST];
	assign lb_on = st.ctrl[oam_pkg::C_HW] & ~tst_on;
	assign same = evt.mel == oam_pkg::MEL_SAME;
	assign tx_hit = evt.valid & ~evt.rx & same & ((evt.kind == oam_pkg::K_LBM & lb_on) |
		(evt.kind == oam_pkg::K_TST & tst_on & st.ctrl[oam_pkg::C_HW] & st.ctrl[oam_pkg::C_OCNT] &
		st.fwd[oam_pkg::DCTL + 1]));
	assign rx_rep = evt.valid & evt.rx & same & ((evt.kind == oam_pkg::K_LBR & lb_on) |
		(evt.kind == oam_pkg::K_TST & tst_on));
	assign rx_req = evt.valid & evt.rx & same & evt.kind == oam_pkg::K_LBM & lb_on;
	assign conv = rx_req & (~st.ctrl[oam_pkg::C_UP] | st.ctrl[oam_pkg::C_UPLB]);
	assign lm_hit = evt.valid & evt.rx & same & st.ctrl[oam_pkg::C_UP] & ((evt.kind == oam_pkg::K_LMM &
		~st.ctrl[oam_pkg::C_UPLB]) | evt.kind == oam_pkg::K_LMR | evt.kind == oam_pkg::K_CCM_LM);
	assign cnt_hit = evt.valid & (evt.kind == oam_pkg::K_DATA | evt.mel == oam_pkg::MEL_HIGH |
		(same & st.fwd[oam_pkg::DCTL + 32'(evt.kind)])) & (~evt.yellow | st.ctrl[oam_pkg::C_YEL]) &
		(evt.kind == oam_pkg::K_DATA | evt.mel != oam_pkg::MEL_LOW);
	assign cls = st.ctrl[oam_pkg::C_MERGE + 32'(evt.cos)] ? oam_pkg::TOP_CLS : evt.cos;
	assign exp_tid = st.rx_tid + 32'h1;
	assign nseq = st.lb_idx[4:0] + 5'h1;
	assign wr_go = psel & penable & st.pready & pwrite & mapped(paddr);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// Software writes land first; hardware updates in the same cycle win.
	always_comb begin
		next_st = st;
		next_st.pready = psel & ~penable;
		if (psel & ~penable) begin
			next_st.pslverr = ~mapped(paddr);
			next_st.prdata = 32'h0;
			if (paddr[11:8] == oam_pkg::CNT_PAGE) begin
				if (mapped(paddr))
					next_st.prdata = st.cnt[paddr[7:2]];
			end else begin
				unique case (paddr)
					oam_pkg::OFS_CTRL: next_st.prdata = st.ctrl;
					oam_pkg::OFS_TX_TID: next_st.prdata = st.tx_tid;
					oam_pkg::OFS_RX_TID: next_st.prdata = st.rx_tid;
					oam_pkg::OFS_LBR_CNT: next_st.prdata = st.lbr_cnt;
					oam_pkg::OFS_LB_IDX: next_st.prdata = st.lb_idx;
					oam_pkg::OFS_PROT: next_st.prdata = st.prot;
					oam_pkg::OFS_MAC_LO: next_st.prdata = st.mac_lo;
					oam_pkg::OFS_MAC_HI: next_st.prdata = st.mac_hi;
					oam_pkg::OFS_FWD: next_st.prdata = st.fwd;
					oam_pkg::OFS_SEQ: next_st.prdata = st.seq;
					default: next_st.prdata = 32'h0;
				endcase
			end
		end
		if (wr_go) begin
			if (paddr[11:8] == oam_pkg::CNT_PAGE) begin
				next_st.cnt[paddr[7:2]] = pwdata;
			end else begin
				unique case (paddr)
					oam_pkg::OFS_CTRL: next_st.ctrl = pwdata;
					oam_pkg::OFS_TX_TID: next_st.tx_tid = pwdata;
					oam_pkg::OFS_RX_TID: next_st.rx_tid = pwdata;
					oam_pkg::OFS_LBR_CNT: next_st.lbr_cnt = pwdata;
					oam_pkg::OFS_LB_IDX: next_st.lb_idx = {22'h0, pwdata[9:0]};
					oam_pkg::OFS_PROT: next_st.prot = pwdata;
					oam_pkg::OFS_MAC_LO: next_st.mac_lo = pwdata;
					oam_pkg::OFS_MAC_HI: next_st.mac_hi = {16'h0, pwdata[15:0]};
					oam_pkg::OFS_FWD: next_st.fwd = pwdata;
					oam_pkg::OFS_SEQ: next_st.seq = pwdata;
					default: next_st.seq = st.seq;
				endcase
			end
		end
		// Default verdict forwards the frame untouched; OAM frames at MEL_LOW are marked discard.
		next_st.res = '0;
		next_st.res.valid = evt.valid;
		next_st.res.port = evt.port;
		next_st.res.ingress_service_index = evt.ingress_service_index;
		next_st.res.dmac = evt.dmac;
		next_st.res.smac = evt.smac;
		next_st.res.tid = evt.tid;
		next_st.res.discard = evt.valid & evt.kind != oam_pkg::K_DATA & evt.mel == oam_pkg::MEL_LOW;
		if (tx_hit & st.ctrl[oam_pkg::C_UPD]) begin
			next_st.res.tid = st.tx_tid;
			next_st.tx_tid = st.tx_tid + 32'h1;
		end
		if (rx_rep) begin
			next_st.lbr_cnt = st.lbr_cnt + 32'h1;
			next_st.res.cpu_copy = st.ctrl[oam_pkg::C_REP_CP];
			if (st.ctrl[oam_pkg::C_UP]) begin
				next_st.res.seq_err = evt.tid[15:0] != exp_tid[15:0];
				next_st.rx_tid = {16'h0, exp_tid[oam_pkg::TID_UP_W - 1:0]};
			end else begin
				next_st.res.seq_err = evt.tid != exp_tid;
				next_st.rx_tid = exp_tid;
			end
		end
		if (rx_req & ~conv)
			next_st.res.cpu_copy = st.ctrl[oam_pkg::C_REQ_CP];
		if (conv) begin
			next_st.res.is_lbr = 1'b1;
			next_st.res.dmac = evt.smac;
			next_st.res.smac = {st.mac_hi[15:0], st.mac_lo};
			if (~st.ctrl[oam_pkg::C_UP]) begin
				next_st.res.ingress_service_index = st.lb_idx[9:0];
				if (st.ctrl[oam_pkg::C_PROT]) begin
					next_st.res.port = st.prot[19:16];
					next_st.res.ingress_service_index = st.prot[9:0];
				end
			end
		end
		if (lm_hit) begin
			next_st.lb_idx[4:0] = nseq;
			next_st.res.rew[31:oam_pkg::REW_SEQ] = nseq;
			next_st.res.cpu_copy = 1'b1;
			unique case (evt.kind)
				oam_pkg::K_LMM: next_st.seq[oam_pkg::SEQ_LMM +: 5] = nseq;
				oam_pkg::K_LMR: next_st.seq[oam_pkg::SEQ_LMR +: 5] = nseq;
				default: next_st.seq[oam_pkg::SEQ_CCM +: 5] = nseq;
			endcase
		end
		// Path counters mirror service counters; port counters count any counted frame with port_hit set.
		if (cnt_hit) begin
			if (evt.svc)
				next_st.cnt[cidx(oam_pkg::SET_SVC, ~evt.rx, cls)] = st.cnt[cidx(oam_pkg::SET_SVC, ~evt.rx, cls)] + 32'h1;
			if (evt.svc & st.ctrl[oam_pkg::C_PATH])
				next_st.cnt[cidx(oam_pkg::SET_PATH, ~evt.rx, cls)] = st.cnt[cidx(oam_pkg::SET_PATH, ~evt.rx, cls)] + 32'h1;
			if (evt.port_hit)
				next_st.cnt[cidx(oam_pkg::SET_PORT, ~evt.rx, cls)] = st.cnt[cidx(oam_pkg::SET_PORT, ~evt.rx, cls)] + 32'h1;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// All state in one flop bank; outputs are taken straight from it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			st <= '0;
		else
			st <= next_st;
	end

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign res = st.res;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_tx_tid_use: assert property (tx_hit & st.ctrl[oam_pkg::C_UPD] |=> res.tid == $past(st.tx_tid) && st.tx_tid == $past(st.tx_tid) + 32'h1)
		else $error("tx transaction id not inserted or advanced");
	a_tx_tid_keep: assert property (tx_hit & ~st.ctrl[oam_pkg::C_UPD] & ~wr_go |=> res.tid == $past(evt.tid) && $stable(st.tx_tid))
		else $error("tx transaction id changed while update disabled");
	a_rx_cmp: assert property (rx_rep & ~st.ctrl[oam_pkg::C_UP] |=> res.seq_err == ($past(evt.tid) != $past(st.rx_tid) + 32'h1))
		else $error("reply id check wrong");
	a_rx_count: assert property (rx_rep |=> st.lbr_cnt == $past(st.lbr_cnt) + 32'h1)
		else $error("reply counter did not advance");
	a_down_conv: assert property (conv & ~st.ctrl[oam_pkg::C_UP] & ~st.ctrl[oam_pkg::C_PROT] |=> res.is_lbr && res.dmac == $past(evt.smac) && res.ingress_service_index == $past(st.lb_idx[9:0]) && res.port == $past(evt.port))
		else $error("down loopback conversion wrong");
	a_prot_loop: assert property (conv & ~st.ctrl[oam_pkg::C_UP] & st.ctrl[oam_pkg::C_PROT] |=> res.port == $past(st.prot[19:16]) && res.ingress_service_index == $past(st.prot[9:0]))
		else $error("protect loopback not used");
	a_up_copy: assert property (rx_req & st.ctrl[oam_pkg::C_UP] & ~st.ctrl[oam_pkg::C_UPLB] |=> !res.is_lbr && res.cpu_copy == $past(st.ctrl[oam_pkg::C_REQ_CP]))
		else $error("in-service request copy wrong");
	a_tst_gate: assert property (evt.valid & evt.rx & evt.kind == oam_pkg::K_TST & ~tst_on & ~wr_go |=> $stable(st.lbr_cnt))
		else $error("test frame handled while disabled");
	a_lm_seq: assert property (lm_hit |=> res.rew[31:27] == st.lb_idx[4:0] && st.lb_idx[4:0] == $past(st.lb_idx[4:0]) + 5'h1)
		else $error("lm sequence not advanced");
	a_low_drop: assert property (evt.valid & evt.kind != oam_pkg::K_DATA & evt.mel == oam_pkg::MEL_LOW |=> res.discard)
		else $error("lower level frame not discarded");
	a_up_conv: assert property (conv & st.ctrl[oam_pkg::C_UP] |=> res.is_lbr && res.dmac == $past(evt.smac))
		else $error("up loopback conversion wrong");
	a_up_low16: assert property (rx_rep & st.ctrl[oam_pkg::C_UP] |=> st.rx_tid[31:16] == 16'h0)
		else $error("up expected id kept upper bits");
	a_tst_tx: assert property (tx_hit & evt.kind == oam_pkg::K_TST & st.ctrl[oam_pkg::C_UPD] |=> res.tid == $past(st.tx_tid))
		else $error("test frame sequence not inserted");
	c_down_loop: cover property (conv & ~st.ctrl[oam_pkg::C_UP]);
	c_up_loop: cover property (conv & st.ctrl[oam_pkg::C_UP]);
	c_tst_rx: cover property (rx_rep & evt.kind == oam_pkg::K_TST);
	c_lm_sample: cover property (lm_hit ##1 lm_hit);
endmodule // oam_engine

// ### dv/oam_peer.sv
// Purpose: Behavioural far end that presents frame events to the OAM engine.
// Assumes: One event per request, launched on the clock edge after go.
// Notes: Idle cycles clear valid and invert every other field so a stale frame never looks valid.
`timescale 1ns/100ps
module oam_peer (
	input wire logic pclk, // System clock.
	input wire logic presetn, // Reset, active low.
	input wire logic go, // Present one frame next cycle.
	input wire oam_pkg::oam_kind_t kind, // Frame kind.
	input wire logic rx, // High for a received frame.
	input wire logic [31:0] tid, // Transaction or sequence field.
	input wire logic [47:0] smac, // Source address of the frame.
	input wire logic [3:0] port, // Port the frame uses.
	output oam_pkg::oam_evt_t evt // Event towards the engine.
);
	// ----------------------------------------------------------------
	// Frame launch
	// ----------------------------------------------------------------
	// Injected and received frames share one path, like host injection does.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt <= '0;
		end else if (go) begin
			evt <= '{1'b1, rx, kind, oam_pkg::MEL_SAME, 3'h2, 1'b0, 1'b1, 1'b0, port, 10'h011,
				48'h0000_0000_0a0b, smac, tid};
		end else begin
			evt <= {1'b0, ~evt[$bits(evt)-2:0]};
		end
	end
endmodule // oam_peer

// ### dv/oam_loopback_test_lm_engine_tb_top.sv
// Purpose: Self-checking bench for the OAM loopback, test and loss engine.
// Assumes: Registers over APB, the peer model supplies frame events.
// Notes: Table rows cover the transaction ID sequence; special cases follow by hand.
`timescale 1ns/100ps
module oam_loopback_test_lm_engine_tb_top;
	typedef struct packed {
		logic [31:0] ctrl;
		oam_pkg::oam_kind_t kind;
		logic rx;
		logic [31:0] tid;
		logic [31:0] exp;
		logic use_tid;
		logic err;
	} oam_row_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, go, rx, slv;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, tid, rd;
	logic [47:0] smac;
	logic [3:0] port;
	oam_pkg::oam_kind_t kind;
	oam_pkg::oam_evt_t evt;
	oam_pkg::oam_res_t res;
	int err_total = 0;
	int checks = 0;
	oam_row_t rows [6] = '{
		'{32'h3, oam_pkg::K_LBM, 1'b0, 32'h0, 32'h5, 1'b1, 1'b0},
		'{32'h3, oam_pkg::K_LBM, 1'b0, 32'h0, 32'h6, 1'b1, 1'b0},
		'{32'h1, oam_pkg::K_LBM, 1'b0, 32'h77, 32'h77, 1'b1, 1'b0},
		'{32'h1, oam_pkg::K_LBR, 1'b1, 32'ha, 32'h0, 1'b0, 1'b0},
		'{32'h1, oam_pkg::K_LBR, 1'b1, 32'ha, 32'h0, 1'b0, 1'b1},
		'{32'h1, oam_pkg::K_LBR, 1'b1, 32'hc, 32'h0, 1'b0, 1'b0}};

	oam_engine dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt), .res(res));
	oam_peer peer (.pclk(pclk), .presetn(presetn), .go(go), .kind(kind), .rx(rx), .tid(tid), .smac(smac),
		.port(port), .evt(evt));

	// Free-running 25 ns clock.
	always #12.5 pclk = ~pclk;

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// The slave answer latency is not assumed; a wait ends on ready or at the retry bound of 20.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Ready is looked at mid-cycle, so the value seen is the one the next rising edge samples.
		do begin @(negedge pclk); n++; end while (pready !== 1'b1 && n < 20);
		if (n >= 20) err_total++;
		rd = prdata;
		slv = pslverr;
		@(posedge pclk);
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic chk_reg(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(48'(rd), 48'(exp));
	endtask
	task automatic send(input oam_pkg::oam_kind_t k, input logic r, input logic [31:0] t, input logic [3:0] p);
		int n;
		n = 0;
		@(posedge pclk);
		go <= 1'b1; kind <= k; rx <= r; tid <= t; smac <= 48'h0a0b_0c0d_0e0f; port <= p;
		@(posedge pclk);
		go <= 1'b0;
		do begin @(negedge pclk); n++; end while (res.valid !== 1'b1 && n < 8);
		if (n >= 8) err_total++;
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
		go = 0; kind = oam_pkg::K_DATA; rx = 0; tid = '0; smac = '0; port = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		chk_reg(oam_pkg::OFS_CTRL, 32'h0);
		apb(1'b0, 12'h0fc, 32'h0);
		chk(48'(slv), 48'h1);
		$display("reset and decode test finished");
		wr(oam_pkg::OFS_TX_TID, 32'h5);
		wr(oam_pkg::OFS_RX_TID, 32'h9);
		foreach (rows[i]) begin
			wr(oam_pkg::OFS_CTRL, rows[i].ctrl);
			send(rows[i].kind, rows[i].rx, rows[i].tid, 4'h3);
			if (rows[i].use_tid) chk(48'(res.tid), 48'(rows[i].exp));
			chk(48'(res.seq_err), 48'(rows[i].err));
		end
		chk_reg(oam_pkg::OFS_TX_TID, 32'h7);
		chk_reg(oam_pkg::OFS_RX_TID, 32'hc);
		chk_reg(oam_pkg::OFS_LBR_CNT, 32'h3);
		$display("transaction id table finished");
		wr(oam_pkg::OFS_MAC_LO, 32'h4455_6677);
		wr(oam_pkg::OFS_MAC_HI, 32'h0000_2233);
		wr(oam_pkg::OFS_LB_IDX, 32'h155);
		wr(oam_pkg::OFS_PROT, 32'h0009_02aa);
		wr(oam_pkg::OFS_CTRL, 32'h1);
		send(oam_pkg::K_LBM, 1'b1, 32'h0, 4'h3);
		chk(48'(res.is_lbr), 48'h1);
		chk(res.dmac, 48'h0a0b_0c0d_0e0f);
		chk(res.smac, 48'h2233_4455_6677);
		chk(48'(res.port), 48'h3);
		chk(48'(res.ingress_service_index), 48'h155);
		wr(oam_pkg::OFS_CTRL, 32'h41);
		send(oam_pkg::K_LBM, 1'b1, 32'h0, 4'h3);
		chk(48'(res.port), 48'h9);
		chk(48'(res.ingress_service_index), 48'h2aa);
		$display("down loopback test finished");
		wr(oam_pkg::OFS_CTRL, 32'h81);
		wr(oam_pkg::OFS_RX_TID, 32'h0001_fffe);
		send(oam_pkg::K_LBR, 1'b1, 32'h1234_ffff, 4'h3);
		chk(48'(res.seq_err), 48'h0);
		chk_reg(oam_pkg::OFS_RX_TID, 32'h0000_ffff);
		wr(oam_pkg::OFS_CTRL, 32'h85);
		send(oam_pkg::K_LBM, 1'b1, 32'h0, 4'h3);
		chk(48'(res.is_lbr), 48'h1);
		chk(res.dmac, 48'h0a0b_0c0d_0e0f);
		// Test frames borrow the reply counter, so the count runs on from the loopback cases.
		wr(oam_pkg::OFS_CTRL, 32'h11);
		wr(oam_pkg::OFS_RX_TID, 32'h0);
		wr(oam_pkg::OFS_FWD, 32'h40);
		send(oam_pkg::K_TST, 1'b1, 32'h1, 4'h3);
		chk(48'(res.seq_err), 48'h0);
		chk(48'(res.cpu_copy), 48'h1);
		chk_reg(oam_pkg::OFS_LBR_CNT, 32'h5);
		wr(oam_pkg::OFS_CTRL, 32'h203);
		wr(oam_pkg::OFS_FWD, 32'h240);
		send(oam_pkg::K_TST, 1'b0, 32'h0, 4'h3);
		chk(48'(res.tid), 48'h7);
		wr(oam_pkg::OFS_FWD, 32'h0);
		send(oam_pkg::K_TST, 1'b1, 32'h2, 4'h3);
		chk_reg(oam_pkg::OFS_LBR_CNT, 32'h5);
		$display("up reply and test frame test finished");
		wr(oam_pkg::OFS_LB_IDX, 32'h140);
		wr(oam_pkg::OFS_CTRL, 32'h81);
		send(oam_pkg::K_LMR, 1'b1, 32'h0, 4'h3);
		chk(48'(res.rew[31:27]), 48'h1);
		send(oam_pkg::K_LMR, 1'b1, 32'h0, 4'h3);
		chk(48'(res.rew[31:27]), 48'h2);
		chk_reg(oam_pkg::OFS_LB_IDX, 32'h142);
		apb(1'b0, oam_pkg::OFS_SEQ, 32'h0);
		chk(48'(rd[25:21]), 48'h2);
		wr(oam_pkg::OFS_CTRL, 32'h1);
		send(oam_pkg::K_DATA, 1'b1, 32'h0, 4'h3);
		chk_reg(12'h108, 32'h1);
		wr(oam_pkg::OFS_CTRL, 32'h0004_0001);
		send(oam_pkg::K_DATA, 1'b1, 32'h0, 4'h3);
		chk_reg(12'h11c, 32'h1);
		chk_reg(12'h108, 32'h1);
		$display("sequence and counter test finished");
		summarize();
	end

	// Watchdog: the whole sequence needs well under a thousand cycles.
	initial begin
		repeat (5000) @(posedge pclk);
		err_total++;
		summarize();
	end
endmodule // oam_loopback_test_lm_engine_tb_top
